/* rtl/rbc_consts.vh */
// constants shared by the ram block clock-mode design
`ifndef RBC_CONSTS_VH
`define RBC_CONSTS_VH

`define RBC_MODE_W 3
`define RBC_MODE_INDEP 3'h0
`define RBC_MODE_IO_TDP 3'h1
`define RBC_MODE_IO_SDP 3'h2
`define RBC_MODE_RW 3'h3
`define RBC_MODE_SINGLE 3'h4

`define RBC_DATA_W 16
`define RBC_ADDR_W 8
`define RBC_LANE_W 8
`define RBC_HALF_BITS 2048

`define RBC_CLR_VAL 1'b0
`define RBC_HALF_LO 1'b0
`define RBC_HALF_HI 1'b1

`endif

/* rtl/rbc_preg.v */
// one clock-gated register group with enable and immediate clear
`timescale 1ns/100ps
module rbc_preg #(
   parameter W = 8
) (
   input wire clk,
   input wire rstn,
   input wire tick,
   input wire en,
   input wire clr,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
`include "rbc_consts.vh"

   reg [W-1:0] q_r;

   always @(posedge clk) begin
      if (!rstn) begin
         q_r <= {W{`RBC_CLR_VAL}};
      end else if (clr) begin
         q_r <= {W{`RBC_CLR_VAL}};
      end else if (tick && en) begin
         q_r <= d;
      end
   end

   // clear shows at once, no edge needed
   assign q = clr ? {W{`RBC_CLR_VAL}} : q_r;

endmodule // rbc_preg

/* rtl/rbc_ram.v */
// dual-port ram block with selectable port clocking modes
// What this block does
// - independent mode: port A registers on clock A, port B registers on clock B
// - independent mode: each port has its own enable and clear
// - independent and true dual-port input/output modes: every register is clearable
// - input/output clocking works for true and simple dual-port use
// - input/output mode: one clock for input registers, another for read output
// - input/output mode: separate enables and clears for input and output sides
// - simple dual-port: all registers clearable except read strobe register
// - read/write mode for simple dual-port, at most two clocks
// - read/write mode: write data, location, strobe on write clock
// - read/write mode: read data, location, strobe on read clock
// - read/write mode: own enable per clock, separate side clears
// - block holds two independent single-port memories of at most 2K bits
// - optionally all input registers share one of the two clocks
// - read output register can be bypassed
// - any byte lane combination writes only selected bytes
`timescale 1ns/100ps
`include "rbc_consts.vh"
module rbc_ram #(
   parameter DATA_W = `RBC_DATA_W,
   parameter ADDR_W = `RBC_ADDR_W
) (
   input wire clk,
   input wire rstn,
   input wire [`RBC_MODE_W-1:0] mode,
   input wire clk_a_in,
   input wire clk_b_in,
   input wire shared_in_clk,
   input wire in_clk_sel,
   input wire cen_in_a,
   input wire cen_out_a,
   input wire clr_in_a,
   input wire clr_out_a,
   input wire cen_in_b,
   input wire cen_out_b,
   input wire clr_in_b,
   input wire clr_out_b,
   input wire bypass_a,
   input wire bypass_b,
   input wire [ADDR_W-1:0] addr_a,
   input wire [DATA_W-1:0] din_a,
   input wire wren_a,
   input wire rden_a,
   input wire [DATA_W/8-1:0] lane_a,
   input wire [ADDR_W-1:0] addr_b,
   input wire [DATA_W/8-1:0] lane_b,
   input wire [DATA_W-1:0] din_b,
   input wire wren_b,
   input wire rden_b,
   output wire [DATA_W-1:0] dout_a,
   output wire [DATA_W-1:0] dout_b
);

   localparam LANES = DATA_W / `RBC_LANE_W;
   localparam IN_W = ADDR_W + DATA_W + 1 + LANES;
   localparam DEPTH = 1 << ADDR_W;

   // write only the selected byte lanes
   function [DATA_W-1:0] lane_merge;
      input [DATA_W-1:0] old_w;
      input [DATA_W-1:0] new_w;
      input [LANES-1:0] sel;
      integer i;
      begin
         lane_merge = old_w;
         for (i = 0; i < LANES; i = i + 1) begin
            if (sel[i]) begin
               lane_merge[i*`RBC_LANE_W +: `RBC_LANE_W] = new_w[i*`RBC_LANE_W +: `RBC_LANE_W];
            end
         end
      end
   endfunction

   // single-port mode pins each port to its own half
   function [ADDR_W-1:0] eff_addr;
      input [ADDR_W-1:0] a;
      input single;
      input half;
      begin
         eff_addr = single ? {half, a[ADDR_W-2:0]} : a;
      end
   endfunction

   reg [DATA_W-1:0] mem [0:DEPTH-1];
   reg clk_a_prev_r;
   reg clk_b_prev_r;
   reg acc_a_r;
   reg acc_b_r;
   reg [DATA_W-1:0] rd_a_r;
   reg [DATA_W-1:0] rd_b_r;

   wire tick_a;
   wire tick_b;
   wire sdp;
   wire single;
   wire tick_shared;

   reg tk_in_a;
   reg en_in_a;
   reg cl_in_a;
   reg tk_out_a;
   reg en_out_a;
   reg cl_out_a;
   reg tk_in_b;
   reg en_in_b;
   reg cl_in_b;
   reg tk_out_b;
   reg en_out_b;
   reg cl_out_b;

   wire [IN_W-1:0] in_q_a;
   wire [IN_W-1:0] in_q_b;
   wire rden_q_a;
   wire rden_q_b;
   wire [DATA_W-1:0] out_q_a;
   wire [DATA_W-1:0] out_q_b;
   wire [ADDR_W-1:0] aq_a;
   wire [ADDR_W-1:0] aq_b;
   wire [DATA_W-1:0] dq_a;
   wire [DATA_W-1:0] dq_b;
   wire wq_a;
   wire wq_b;
   wire [LANES-1:0] lq_a;
   wire [LANES-1:0] lq_b;
   wire do_wr_a;
   wire do_wr_b;
   wire do_rd_a;
   wire do_rd_b;

   // port clocks arrive as sampled levels; a rising level is a clock event
   assign tick_a = clk_a_in & ~clk_a_prev_r;
   assign tick_b = clk_b_in & ~clk_b_prev_r;
   assign sdp = (mode == `RBC_MODE_IO_SDP) || (mode == `RBC_MODE_RW);
   assign single = (mode == `RBC_MODE_SINGLE);
   assign tick_shared = in_clk_sel ? tick_b : tick_a;

   // clock, enable and clear routing per register group
   always @* begin
      tk_in_a = tick_a;
      en_in_a = cen_in_a;
      cl_in_a = clr_in_a;
      tk_out_a = tick_a;
      en_out_a = cen_in_a;
      cl_out_a = clr_in_a;
      tk_in_b = tick_b;
      en_in_b = cen_in_b;
      cl_in_b = clr_in_b;
      tk_out_b = tick_b;
      en_out_b = cen_in_b;
      cl_out_b = clr_in_b;
      case (mode)
         `RBC_MODE_INDEP, `RBC_MODE_SINGLE: begin
            tk_in_a = tick_a;
            tk_in_b = tick_b;
         end
         `RBC_MODE_IO_TDP, `RBC_MODE_IO_SDP: begin
            tk_in_a = tick_a;
            tk_in_b = tick_a;
            tk_out_a = tick_b;
            tk_out_b = tick_b;
            en_out_a = cen_out_a;
            cl_out_a = clr_out_a;
            en_out_b = cen_out_b;
            cl_out_b = clr_out_b;
         end
         `RBC_MODE_RW: begin
            tk_in_a = tick_a;
            tk_in_b = tick_b;
            tk_out_b = tick_b;
            en_out_b = cen_in_b;
            cl_out_b = clr_in_b;
         end
         default: begin
            tk_in_a = tick_a;
            tk_in_b = tick_b;
         end
      endcase
      if (shared_in_clk) begin
         tk_in_a = tick_shared;
         tk_in_b = tick_shared;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         clk_a_prev_r <= `RBC_CLR_VAL;
         clk_b_prev_r <= `RBC_CLR_VAL;
      end else begin
         clk_a_prev_r <= clk_a_in;
         clk_b_prev_r <= clk_b_in;
      end
   end

   // input side: address, data, write strobe, lanes
   rbc_preg #(.W(IN_W)) u_in_a (
      .clk(clk),
      .rstn(rstn),
      .tick(tk_in_a),
      .en(en_in_a),
      .clr(cl_in_a),
      .d({addr_a, din_a, wren_a, lane_a}),
      .q(in_q_a)
   );

   rbc_preg #(.W(IN_W)) u_in_b (
      .clk(clk),
      .rstn(rstn),
      .tick(tk_in_b),
      .en(en_in_b),
      .clr(cl_in_b),
      .d({addr_b, din_b, wren_b, lane_b}),
      .q(in_q_b)
   );

   // read strobe registers lose their clear in simple dual-port use
   rbc_preg #(.W(1)) u_rden_a (
      .clk(clk),
      .rstn(rstn),
      .tick(tk_in_a),
      .en(en_in_a),
      .clr(cl_in_a & ~sdp),
      .d(rden_a),
      .q(rden_q_a)
   );

   rbc_preg #(.W(1)) u_rden_b (
      .clk(clk),
      .rstn(rstn),
      .tick(tk_in_b),
      .en(en_in_b),
      .clr(cl_in_b & ~sdp),
      .d(rden_b),
      .q(rden_q_b)
   );

   assign aq_a = in_q_a[IN_W-1 -: ADDR_W];
   assign dq_a = in_q_a[LANES+DATA_W : LANES+1];
   assign wq_a = in_q_a[LANES];
   assign lq_a = in_q_a[LANES-1:0];
   assign aq_b = in_q_b[IN_W-1 -: ADDR_W];
   assign dq_b = in_q_b[LANES+DATA_W : LANES+1];
   assign wq_b = in_q_b[LANES];
   assign lq_b = in_q_b[LANES-1:0];

   // simple dual-port: A writes only, B reads only
   assign do_wr_a = acc_a_r & wq_a;
   assign do_wr_b = acc_b_r & wq_b & ~sdp;
   // single-port: a write cycle does no read
   assign do_rd_a = acc_a_r & rden_q_a & ~sdp & ~(single & wq_a);
   assign do_rd_b = acc_b_r & rden_q_b & ~(single & wq_b);

   // array access one cycle after the input registers load
   always @(posedge clk) begin
      if (!rstn) begin
         acc_a_r <= `RBC_CLR_VAL;
         acc_b_r <= `RBC_CLR_VAL;
      end else begin
         acc_a_r <= tk_in_a & en_in_a & ~cl_in_a;
         acc_b_r <= tk_in_b & en_in_b & ~cl_in_b;
      end
   end

   // port B write follows port A, so B wins on a shared address
   always @(posedge clk) begin
      if (do_wr_a) begin
         mem[eff_addr(aq_a, single, `RBC_HALF_LO)] <=
            lane_merge(mem[eff_addr(aq_a, single, `RBC_HALF_LO)], dq_a, lq_a);
      end
      if (do_wr_b) begin
         mem[eff_addr(aq_b, single, `RBC_HALF_HI)] <=
            lane_merge(mem[eff_addr(aq_b, single, `RBC_HALF_HI)], dq_b, lq_b);
      end
   end

   // halves are independent single-port memories
   always @(posedge clk) begin
      if (!rstn) begin
         rd_a_r <= {DATA_W{`RBC_CLR_VAL}};
         rd_b_r <= {DATA_W{`RBC_CLR_VAL}};
      end else begin
         // read latch is part of the output group, so its clear empties it too
         if (cl_out_a) begin
            rd_a_r <= {DATA_W{`RBC_CLR_VAL}};
         end else if (do_rd_a) begin
            rd_a_r <= mem[eff_addr(aq_a, single, `RBC_HALF_LO)];
         end
         if (cl_out_b) begin
            rd_b_r <= {DATA_W{`RBC_CLR_VAL}};
         end else if (do_rd_b) begin
            rd_b_r <= mem[eff_addr(aq_b, single, `RBC_HALF_HI)];
         end
      end
   end

   rbc_preg #(.W(DATA_W)) u_out_a (
      .clk(clk),
      .rstn(rstn),
      .tick(tk_out_a),
      .en(en_out_a),
      .clr(cl_out_a),
      .d(rd_a_r),
      .q(out_q_a)
   );

   rbc_preg #(.W(DATA_W)) u_out_b (
      .clk(clk),
      .rstn(rstn),
      .tick(tk_out_b),
      .en(en_out_b),
      .clr(cl_out_b),
      .d(rd_b_r),
      .q(out_q_b)
   );

   // bypass skips the output stage; output clear still masks
   assign dout_a = bypass_a ? (cl_out_a ? {DATA_W{`RBC_CLR_VAL}} : rd_a_r) : out_q_a;
   assign dout_b = bypass_b ? (cl_out_b ? {DATA_W{`RBC_CLR_VAL}} : rd_b_r) : out_q_b;

endmodule // rbc_ram

/* verification/rbc_ram_asserts.sv */
// concurrent checks on the ram block port outputs
`timescale 1ns/100ps
`include "rbc_consts.vh"
module rbc_ram_chk #(
   parameter DATA_W = 16
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [`RBC_MODE_W-1:0] mode,
   input wire logic clk_b_in,
   input wire logic cen_in_a,
   input wire logic clr_in_a,
   input wire logic clr_out_a,
   input wire logic clr_in_b,
   input wire logic clr_out_b,
   input wire logic bypass_a,
   input wire logic bypass_b,
   input wire logic [DATA_W-1:0] dout_a,
   input wire logic [DATA_W-1:0] dout_b
);
   logic prev_b_r;
   logic tick_b;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   always @(posedge clk) begin
      prev_b_r <= rstn ? clk_b_in : 1'b0;
   end
   assign tick_b = clk_b_in & ~prev_b_r;
   sequence s_zero;
      dout_a == 0 && dout_b == 0;
   endsequence
   chk_rst_out_zero: assert property ($rose(rstn) |-> s_zero [*2])
      else $error("outputs not zero after reset");
   chk_clr_a_zero: assert property ((mode == 0 || mode == 3 || mode == 4) && clr_in_a |->
      dout_a == 0)
      else $error("port a output not cleared");
   chk_clr_out_b: assert property ((mode == 1 || mode == 2) && clr_out_b |-> dout_b == 0)
      else $error("port b output group not cleared");
   chk_rw_clr_b: assert property (mode == 3 && clr_in_b |-> dout_b == 0)
      else $error("read side not cleared");
   chk_clr_keeps_zero: assert property (mode == 0 && bypass_a && $fell(clr_in_a) |->
      dout_a == 0)
      else $error("stored value survived clear");
   chk_hold_en_low: assert property (mode == 0 && !cen_in_a && !$past(cen_in_a) && !clr_in_a
      |=> mode != 0 || clr_in_a || $changed(bypass_a) || $stable(dout_a))
      else $error("port a changed with enable low");
   chk_b_own_tick: assert property (mode == 0 && !bypass_b && !tick_b
      |=> mode != 0 || clr_in_b || $changed(bypass_b) || $stable(dout_b))
      else $error("port b output moved without its clock");
   chk_io_out_tick: assert property (mode == 1 && !bypass_a && !tick_b
      |=> mode != 1 || clr_out_a || $changed(bypass_a) || $stable(dout_a))
      else $error("output register moved without output clock");
endmodule // rbc_ram_chk
bind rbc_ram rbc_ram_chk #(.DATA_W(DATA_W)) u_chk (.clk, .rstn, .mode, .clk_b_in, .cen_in_a,
   .clr_in_a, .clr_out_a, .clr_in_b, .clr_out_b, .bypass_a, .bypass_b, .dout_a, .dout_b);

/* verification/rbc_fab.sv */
// fabric-side model raising each port clock for one cycle per request
`timescale 1ns/100ps
module rbc_fab (
   input wire logic clk,
   input wire logic go_a,
   input wire logic go_b,
   output logic clk_a_in,
   output logic clk_b_in
);
   logic [1:0] pend_r = 2'h0;
   // clocks stay low between frames, so ticks are at least 2 cycles apart
   always @(posedge clk) begin
      pend_r <= {go_b, go_a};
   end
   always @(negedge clk) begin
      {clk_b_in, clk_a_in} <= pend_r;
   end
endmodule // rbc_fab

/* verification/rbc_ram_tb_top.sv */
// self-checking bench for the ram block clock modes
`timescale 1ns/100ps
module rbc_ram_tb_top;
   logic clk = 1'b1;
   logic rstn = 1'b0;
   logic [2:0] mode = 3'h0;
   logic shared_in_clk = 1'b0, in_clk_sel = 1'b0, go_a = 1'b0, go_b = 1'b0;
   logic cen_in_a = 1'b1, cen_out_a = 1'b1, clr_in_a = 1'b0, clr_out_a = 1'b0;
   logic cen_in_b = 1'b1, cen_out_b = 1'b1, clr_in_b = 1'b0, clr_out_b = 1'b0;
   logic bypass_a = 1'b1, bypass_b = 1'b0, wren_a = 1'b0, rden_a = 1'b0;
   logic wren_b = 1'b0, rden_b = 1'b0;
   logic [7:0] addr_a = 8'h00, addr_b = 8'h00;
   logic [15:0] din_a = 16'h0000, din_b = 16'h0000;
   logic [1:0] lane_a = 2'h0, lane_b = 2'h0;
   wire clk_a_in, clk_b_in;
   wire [15:0] dout_a, dout_b;
   int fails = 0, n_checks = 0;
   initial forever #12.5 clk = ~clk;
   rbc_fab u_fab (.clk, .go_a, .go_b, .clk_a_in, .clk_b_in);
   rbc_ram u_dut (.clk, .rstn, .mode, .clk_a_in, .clk_b_in, .shared_in_clk, .in_clk_sel,
      .cen_in_a, .cen_out_a, .clr_in_a, .clr_out_a, .cen_in_b, .cen_out_b, .clr_in_b,
      .clr_out_b, .bypass_a, .bypass_b, .addr_a, .din_a, .wren_a, .rden_a, .lane_a, .addr_b,
      .lane_b, .din_b, .wren_b, .rden_b, .dout_a, .dout_b);
   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task set_a(input logic w, r, input logic [7:0] a, input logic [15:0] d, input logic [1:0] l);
      {wren_a, rden_a, addr_a, din_a, lane_a} = {w, r, a, d, l};
   endtask
   task set_b(input logic w, r, input logic [7:0] a, input logic [15:0] d, input logic [1:0] l);
      {wren_b, rden_b, addr_b, din_b, lane_b} = {w, r, a, d, l};
   endtask
   // one tick per port, then wait until the array access has landed
   task tk(input logic a, input logic b);
      @(negedge clk);
      go_a = a;
      go_b = b;
      @(negedge clk);
      go_a = 1'b0;
      go_b = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task t_indep;
      mode = 3'h0;
      set_a(1, 0, 8'h05, 16'h1234, 2'h3);
      tk(1, 0);
      set_a(1, 0, 8'h05, 16'hABCD, 2'h1);
      tk(1, 0);
      set_a(0, 1, 8'h05, 16'h0000, 2'h0);
      set_b(0, 1, 8'h05, 16'h0000, 2'h0);
      tk(1, 1);
      chk("indep_lane", 16'h12CD, dout_a);
      chk("indep_b_stage", 16'h0000, dout_b);
      tk(0, 1);
      chk("indep_b_out", 16'h12CD, dout_b);
      $display("test indep done");
   endtask
   task t_hold;
      cen_in_a = 1'b0;
      set_a(1, 0, 8'h05, 16'h5555, 2'h3);
      tk(1, 0);
      chk("hold_latch", 16'h12CD, dout_a);
      cen_in_a = 1'b1;
      set_a(0, 1, 8'h05, 16'h0000, 2'h0);
      tk(1, 0);
      chk("hold_mem", 16'h12CD, dout_a);
      clr_in_a = 1'b1;
      #1 chk("clr_a", 16'h0000, dout_a);
      chk("clr_b_kept", 16'h12CD, dout_b);
      @(negedge clk);
      clr_in_a = 1'b0;
      $display("test hold done");
   endtask
   task t_rw;
      mode = 3'h3;
      bypass_b = 1'b1;
      set_a(1, 0, 8'h21, 16'h0F0F, 2'h3);
      set_b(1, 0, 8'h21, 16'h1111, 2'h3);
      tk(1, 1);
      set_b(0, 1, 8'h21, 16'h0000, 2'h0);
      tk(0, 1);
      chk("rw_read", 16'h0F0F, dout_b);
      clr_in_b = 1'b1;
      #1 chk("rw_clr", 16'h0000, dout_b);
      @(negedge clk);
      clr_in_b = 1'b0;
      $display("test rw done");
   endtask
   task t_single;
      mode = 3'h4;
      set_a(1, 0, 8'h03, 16'hAAAA, 2'h3);
      set_b(1, 0, 8'h03, 16'h5555, 2'h3);
      tk(1, 1);
      set_a(0, 1, 8'h03, 16'h0000, 2'h0);
      set_b(0, 1, 8'h03, 16'h0000, 2'h0);
      tk(1, 1);
      chk("single_a", 16'hAAAA, dout_a);
      chk("single_b", 16'h5555, dout_b);
      $display("test single done");
   endtask
   task t_io;
      mode = 3'h1;
      bypass_a = 1'b0;
      clr_out_a = 1'b1;
      @(negedge clk);
      clr_out_a = 1'b0;
      set_a(1, 0, 8'h07, 16'h7E57, 2'h3);
      tk(1, 0);
      set_a(0, 1, 8'h07, 16'h0000, 2'h0);
      tk(1, 0);
      chk("io_wait", 16'h0000, dout_a);
      tk(0, 1);
      chk("io_out", 16'h7E57, dout_a);
      clr_in_a = 1'b1;
      clr_out_b = 1'b1;
      #1 chk("io_sep", 16'h7E57, dout_a);
      chk("io_clr_b", 16'h0000, dout_b);
      @(negedge clk);
      clr_in_a = 1'b0;
      clr_out_b = 1'b0;
      $display("test io done");
   endtask
   task t_sdp;
      mode = 3'h2;
      shared_in_clk = 1'b1;
      in_clk_sel = 1'b1;
      set_a(1, 0, 8'h09, 16'hC3C3, 2'h3);
      set_b(0, 0, 8'h09, 16'h0000, 2'h0);
      tk(0, 1);
      set_a(1, 0, 8'h09, 16'h3C3C, 2'h3);
      set_b(0, 1, 8'h09, 16'h0000, 2'h0);
      tk(1, 0);
      chk("sdp_shared_hold", 16'h0000, dout_b);
      set_a(0, 0, 8'h09, 16'h0000, 2'h0);
      tk(0, 1);
      chk("sdp_shared_read", 16'hC3C3, dout_b);
      bypass_b = 1'b0;
      cen_out_b = 1'b0;
      tk(0, 1);
      chk("sdp_out_hold", 16'h0000, dout_b);
      cen_out_b = 1'b1;
      tk(0, 1);
      chk("sdp_out", 16'hC3C3, dout_b);
      shared_in_clk = 1'b0;
      in_clk_sel = 1'b0;
      $display("test sdp done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      t_indep;
      t_hold;
      t_rw;
      t_single;
      t_io;
      t_sdp;
      end_of_test;
   end
   initial begin
      #(25 * 2000);
      fails++;
      end_of_test;
   end
endmodule // rbc_ram_tb_top
